// [hw/scbbx_regs.vh]
// Constants for the shift, carry, bit and branch execution unit
`ifndef SCBBX_REGS_VH
`define SCBBX_REGS_VH

// Widths
`define SCBBX_INSTR_W      14
`define SCBBX_PC_W         15
`define SCBBX_DATA_W       8
`define SCBBX_FADDR_W      7
`define SCBBX_BIDX_W       3
`define SCBBX_BRK_W        9

// Reset values and counter increments
`define SCBBX_PC_RST       15'h0000
`define SCBBX_W_RST        8'h00
`define SCBBX_FLAG_RST     1'b0
`define SCBBX_PC_ONE       15'h0001
`define SCBBX_PC_TWO       15'h0002
`define SCBBX_FADDR_RST    7'h00
`define SCBBX_DATA_RST     8'h00

// Instruction fields
`define SCBBX_FADDR_HI     6
`define SCBBX_FADDR_LO     0
`define SCBBX_DEST_BIT     7
`define SCBBX_BIDX_HI      9
`define SCBBX_BIDX_LO      7
`define SCBBX_BRK_HI       8
`define SCBBX_BRK_LO       0
`define SCBBX_BRK_SIGN     8
`define SCBBX_BRK_EXT_W    6
`define SCBBX_BIT_ONE      8'h01

// Opcode fields and values
`define SCBBX_OPB_HI       13
`define SCBBX_OPB_LO       8
`define SCBBX_OPK_HI       13
`define SCBBX_OPK_LO       10
`define SCBBX_OPR_HI       13
`define SCBBX_OPR_LO       9
`define SCBBX_OP_ASR       6'h37
`define SCBBX_OP_ADDC      6'h3D
`define SCBBX_OP_BCLR      4'h4
`define SCBBX_OP_SKZ       4'h6
`define SCBBX_OP_SKO       4'h7
`define SCBBX_OP_RJMP      5'h19

// Destination select values
`define SCBBX_DEST_W       1'b0
`define SCBBX_DEST_F       1'b1

// Adder slices
`define SCBBX_NIB_W        4
`define SCBBX_NIB_CARRY    4
`define SCBBX_SUM_CARRY    8

`endif

// [hw/scbbx_alu.v]
// Result and flag datapath of the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "scbbx_regs.vh"

module scbbx_alu (
  // Operands
  input  wire [7:0] w_i,
  input  wire [7:0] f_i,
  input  wire       c_i,
  input  wire [2:0] bit_sel_i,
  // Operation select
  input  wire       asr_i,
  input  wire       addc_i,
  input  wire       bclr_i,
  // Results
  output reg  [7:0] res_o,
  output reg        c_o,
  output reg        dc_o,
  output wire       z_o,
  output wire       bit_val_o
);

  wire [8:0] sum;
  wire [4:0] nib;
  wire [7:0] kept;
  wire [7:0] clr_mask;

  assign sum = {1'b0, w_i} + {1'b0, f_i} + {8'h00, c_i};
  assign nib = {1'b0, w_i[3:0]} + {1'b0, f_i[3:0]} + {4'h0, c_i};

  // Per-bit clear mask
  assign clr_mask = `SCBBX_BIT_ONE << bit_sel_i;
  genvar i;
  generate
    for (i = 0; i < `SCBBX_DATA_W; i = i + 1) begin : g_bit
      assign kept[i] = f_i[i] & ~clr_mask[i];
    end
  endgenerate

  assign bit_val_o = f_i[bit_sel_i];
  assign z_o       = (res_o == 8'h00);

  always @* begin
    res_o = f_i;
    c_o   = c_i;
    dc_o  = 1'b0;
    if (asr_i) begin
      res_o = {f_i[7], f_i[7:1]};
      c_o   = f_i[0];
    end else if (addc_i) begin
      res_o = sum[7:0];
      c_o   = sum[`SCBBX_SUM_CARRY];
      dc_o  = nib[`SCBBX_NIB_CARRY];
    end else if (bclr_i) begin
      res_o = kept;
    end
  end

endmodule
`default_nettype wire

// [hw/scbbx_exec.v]
// Execution unit for shift, add with carry, bit clear, bit skips and relative jump
// How it works
// - Shift right, old bit 0 into carry
// - Bit 7 of shift result keeps sign
// - Destination bit picks accumulator or file register
// - Add W, file, carry; set C, DC, Z
// - Bit clear zeroes selected bit only
// - Skip-if-zero runs next when bit is one
// - Skip-if-zero on zero: next becomes no-op
// - Skip-if-one on one: next becomes no-op
// - Jump to incremented counter plus signed offset
// - Relative jump takes two cycles, flushes next
`timescale 1ns/1ps
`default_nettype none
`include "scbbx_regs.vh"

module scbbx_exec (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        resetn_i,
  // Instruction stream
  input  wire        instr_valid_i,
  input  wire [13:0] instr_i,
  // File register read
  output wire [6:0]  file_raddr_o,
  input  wire [7:0]  file_rdata_i,
  // File register write
  output reg         file_we_o,
  output reg  [6:0]  file_waddr_o,
  output reg  [7:0]  file_wdata_o,
  // Core state
  output wire [14:0] program_counter_o,
  output wire [7:0]  w_o,
  output wire        carry_o,
  output wire        nibble_overflow_bit_o,
  output wire        zero_o,
  // Cycle status
  output wire        no_op_cycle_o,
  output reg         instr_done_o
);

  localparam [1:0] ST_EXEC  = 2'b01;
  localparam [1:0] ST_FLUSH = 2'b10;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [14:0] pc_r;
  reg  [14:0] pc_nxt;
  reg  [7:0]  w_r;
  reg  [7:0]  w_nxt;
  reg         c_r;
  reg         c_nxt;
  reg         dc_r;
  reg         dc_nxt;
  reg         z_r;
  reg         z_nxt;
  reg         we_nxt;
  reg  [7:0]  wdata_nxt;
  reg  [6:0]  waddr_nxt;
  reg         done_nxt;

  wire        take;
  wire        dec_asr;
  wire        dec_addc;
  wire        dec_bclr;
  wire        dec_skz;
  wire        dec_sko;
  wire        dec_rjmp;
  wire        dest;
  wire [2:0]  bit_sel;
  wire [8:0]  jump_k;
  wire [14:0] pc_inc;
  wire [14:0] pc_jump;
  wire [14:0] pc_skip;
  wire [7:0]  alu_res;
  wire        alu_c;
  wire        alu_dc;
  wire        alu_z;
  wire        bit_val;

  // Decode
  assign take     = instr_valid_i & (state_r == ST_EXEC);
  assign dec_asr  = take & (instr_i[`SCBBX_OPB_HI:`SCBBX_OPB_LO] == `SCBBX_OP_ASR);
  assign dec_addc = take & (instr_i[`SCBBX_OPB_HI:`SCBBX_OPB_LO] == `SCBBX_OP_ADDC);
  assign dec_bclr = take & (instr_i[`SCBBX_OPK_HI:`SCBBX_OPK_LO] == `SCBBX_OP_BCLR);
  assign dec_skz  = take & (instr_i[`SCBBX_OPK_HI:`SCBBX_OPK_LO] == `SCBBX_OP_SKZ);
  assign dec_sko  = take & (instr_i[`SCBBX_OPK_HI:`SCBBX_OPK_LO] == `SCBBX_OP_SKO);
  assign dec_rjmp = take & (instr_i[`SCBBX_OPR_HI:`SCBBX_OPR_LO] == `SCBBX_OP_RJMP);

  assign dest         = instr_i[`SCBBX_DEST_BIT];
  assign bit_sel      = instr_i[`SCBBX_BIDX_HI:`SCBBX_BIDX_LO];
  assign jump_k       = instr_i[`SCBBX_BRK_HI:`SCBBX_BRK_LO];
  assign file_raddr_o = instr_i[`SCBBX_FADDR_HI:`SCBBX_FADDR_LO];

  // Next address, incremented and relative
  assign pc_inc  = pc_r + `SCBBX_PC_ONE;
  assign pc_jump = pc_inc + {{`SCBBX_BRK_EXT_W{jump_k[`SCBBX_BRK_SIGN]}}, jump_k};
  // Skip resumes past the discarded word
  assign pc_skip = pc_r + `SCBBX_PC_TWO;

  scbbx_alu u_alu (
    .w_i       (w_r),
    .f_i       (file_rdata_i),
    .c_i       (c_r),
    .bit_sel_i (bit_sel),
    .asr_i     (dec_asr),
    .addc_i    (dec_addc),
    .bclr_i    (dec_bclr),
    .res_o     (alu_res),
    .c_o       (alu_c),
    .dc_o      (alu_dc),
    .z_o       (alu_z),
    .bit_val_o (bit_val)
  );

  // Next state
  always @* begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    w_nxt     = w_r;
    c_nxt     = c_r;
    dc_nxt    = dc_r;
    z_nxt     = z_r;
    we_nxt    = 1'b0;
    wdata_nxt = file_wdata_o;
    waddr_nxt = file_waddr_o;
    done_nxt  = 1'b0;
    case (state_r)
      ST_EXEC: begin
        if (instr_valid_i) begin
          pc_nxt   = pc_inc;
          done_nxt = 1'b1;
          if (dec_asr | dec_addc) begin
            c_nxt = alu_c;
            z_nxt = alu_z;
            if (dec_addc) begin
              dc_nxt = alu_dc;
            end
            if (dest == `SCBBX_DEST_W) begin
              w_nxt = alu_res;
            end else begin
              we_nxt    = 1'b1;
              waddr_nxt = file_raddr_o;
              wdata_nxt = alu_res;
            end
          end else if (dec_bclr) begin
            we_nxt    = 1'b1;
            waddr_nxt = file_raddr_o;
            wdata_nxt = alu_res;
          end else if (dec_skz) begin
            if (!bit_val) begin
              pc_nxt    = pc_skip;
              state_nxt = ST_FLUSH;
              done_nxt  = 1'b0;
            end else begin
              done_nxt  = 1'b1;
            end
          end else if (dec_sko) begin
            if (bit_val) begin
              pc_nxt    = pc_skip;
              state_nxt = ST_FLUSH;
              done_nxt  = 1'b0;
            end
          end else if (dec_rjmp) begin
            pc_nxt    = pc_jump;
            state_nxt = ST_FLUSH;
            done_nxt  = 1'b0;
          end
        end
      end
      ST_FLUSH: begin
        // Fetched word discarded, executed as a no-op
        if (instr_valid_i) begin
          state_nxt = ST_EXEC;
          done_nxt  = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_EXEC;
      end
    endcase
  end

  // Registers
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r      <= ST_EXEC;
      pc_r         <= `SCBBX_PC_RST;
      w_r          <= `SCBBX_W_RST;
      c_r          <= `SCBBX_FLAG_RST;
      dc_r         <= `SCBBX_FLAG_RST;
      z_r          <= `SCBBX_FLAG_RST;
      file_we_o    <= 1'b0;
      file_waddr_o <= `SCBBX_FADDR_RST;
      file_wdata_o <= `SCBBX_DATA_RST;
      instr_done_o <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      pc_r         <= pc_nxt;
      w_r          <= w_nxt;
      c_r          <= c_nxt;
      dc_r         <= dc_nxt;
      z_r          <= z_nxt;
      file_we_o    <= we_nxt;
      file_waddr_o <= waddr_nxt;
      file_wdata_o <= wdata_nxt;
      instr_done_o <= done_nxt;
    end
  end

  // Outputs
  assign program_counter_o     = pc_r;
  assign w_o                   = w_r;
  assign carry_o               = c_r;
  assign nibble_overflow_bit_o = dc_r;
  assign zero_o                = z_r;
  assign no_op_cycle_o         = state_r[1];

endmodule
`default_nettype wire

// [tb/scbbx_exec_properties.sv]
// Assertions for the execution unit
`timescale 1ns/1ps
`default_nettype none
module scbbx_exec_props (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        instr_valid_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0]  file_rdata_i,
  input wire logic        file_we_o,
  input wire logic [7:0]  file_wdata_o,
  input wire logic [14:0] program_counter_o,
  input wire logic [7:0]  w_o,
  input wire logic        carry_o,
  input wire logic        nibble_overflow_bit_o,
  input wire logic        zero_o,
  input wire logic        no_op_cycle_o,
  input wire logic        instr_done_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire       ex  = instr_valid_i && !no_op_cycle_o;
  wire       asr = ex && instr_i[13:8] == 6'h37;
  wire       adc = ex && instr_i[13:8] == 6'h3D;
  wire       bcl = ex && instr_i[13:10] == 4'h4;
  wire       bt  = file_rdata_i[instr_i[9:7]];
  wire       skp = ex && (instr_i[13:10] == 4'h6 && !bt || instr_i[13:10] == 4'h7 && bt);
  wire       pas = ex && (instr_i[13:10] == 4'h6 && bt || instr_i[13:10] == 4'h7 && !bt);
  wire       jmp = ex && instr_i[13:9] == 5'h19;
  wire [7:0] res = file_we_o ? file_wdata_o : w_o;
  // Taken skip or jump, then the word that gets discarded
  sequence s_flush;
    (skp || jmp) ##1 instr_valid_i;
  endsequence
  a_shift_carry: assert property (asr |=> carry_o == $past(file_rdata_i[0]))
    else $error("shift carry");
  a_shift_sign: assert property (asr |=> res == {$past(file_rdata_i[7]), $past(file_rdata_i[7:1])})
    else $error("shift result");
  a_dest_select: assert property (asr || adc |=> file_we_o == $past(instr_i[7]))
    else $error("destination");
  a_add_sum: assert property (adc |=> {carry_o, res} == $past(w_o) + $past(file_rdata_i) + $past(carry_o))
    else $error("add sum");
  a_zero_flag: assert property (asr || adc |=> zero_o == (res == 8'h00))
    else $error("zero flag");
  a_bit_clear: assert property (bcl |=> file_we_o
    && file_wdata_o == ($past(file_rdata_i) & ~(8'h01 << $past(instr_i[9:7]))))
    else $error("bit clear");
  a_skip_taken: assert property (skp |=> no_op_cycle_o && !instr_done_o
    && program_counter_o == $past(program_counter_o) + 15'h0002)
    else $error("skip");
  a_skip_passed: assert property (pas |=> !no_op_cycle_o && instr_done_o
    && program_counter_o == $past(program_counter_o) + 15'h0001)
    else $error("skip passed");
  a_jump_target: assert property (jmp |=> no_op_cycle_o
    && program_counter_o == $past(program_counter_o) + 15'h0001 + {{6{$past(instr_i[8])}}, $past(instr_i[8:0])})
    else $error("jump target");
  a_flush_drop: assert property (s_flush |=> !file_we_o && instr_done_o && $stable(program_counter_o))
    else $error("flush");
  a_flags_keep: assert property (bcl || skp || jmp |=> $stable({carry_o, nibble_overflow_bit_o, zero_o}))
    else $error("flags");
endmodule
bind scbbx_exec scbbx_exec_props u_props (.core_clk_i, .resetn_i, .instr_valid_i, .instr_i, .file_rdata_i, .file_we_o,
  .file_wdata_o, .program_counter_o, .w_o, .carry_o, .nibble_overflow_bit_o, .zero_o, .no_op_cycle_o, .instr_done_o);
`default_nettype wire

// [tb/scbbx_exec_tb.sv]
// Testbench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module scbbx_exec_tb;
  logic        core_clk_i = 0;
  logic        resetn_i = 0;
  logic        instr_valid_i = 0;
  logic [13:0] instr_i = 0;
  logic [7:0]  file_rdata_i = 0;
  wire         file_we_o, carry_o, nibble_overflow_bit_o, zero_o, no_op_cycle_o, instr_done_o;
  wire  [7:0]  file_wdata_o, w_o;
  wire  [14:0] program_counter_o;
  wire  [6:0]  file_raddr_o, file_waddr_o;
  logic [14:0] pc0;
  logic [2:0]  fl;
  int          mismatches = 0;
  int          compares = 0;
  // Instruction, file data, expected {we, wdata, w, c, dc, z}
  logic [41:0] rows [6] = '{{14'h3703, 8'h81, 20'h00604}, {14'h3D85, 8'h3F, 20'h80607},
    {14'h3782, 8'h7E, 20'h9FE02}, {14'h1389, 8'hFF, 20'hBFE02}, {14'h3D04, 8'h40, 20'h3F805},
    {14'h1001, 8'h01, 20'h80005}};
  scbbx_exec u_scbbx_exec (.core_clk_i, .resetn_i, .instr_valid_i, .instr_i, .file_raddr_o, .file_rdata_i,
    .file_we_o, .file_waddr_o, .file_wdata_o, .program_counter_o, .w_o, .carry_o, .nibble_overflow_bit_o,
    .zero_o, .no_op_cycle_o, .instr_done_o);
  always #2 core_clk_i = ~core_clk_i;
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task issue(input logic [13:0] ins, input logic [7:0] rd);
    @(posedge core_clk_i);
    #1 instr_valid_i = 1;
    instr_i = ins;
    file_rdata_i = rd;
    @(posedge core_clk_i);
    #1 instr_valid_i = 0;
  endtask
  task flow(input logic [13:0] ins, input logic [7:0] rd, input logic tk, input logic [14:0] off);
    pc0 = program_counter_o;
    fl = {carry_o, nibble_overflow_bit_o, zero_o};
    issue(ins, rd);
    chk({no_op_cycle_o, instr_done_o, program_counter_o}, {tk, !tk, pc0 + off});
    if (tk) begin
      issue(14'h1001, 8'hFF);
      chk({file_we_o, no_op_cycle_o, instr_done_o, program_counter_o}, {3'b001, pc0 + off});
    end
    chk(fl, {carry_o, nibble_overflow_bit_o, zero_o});
    $display("flow %h done", ins);
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000 mismatches++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    #1 resetn_i = 1;
    foreach (rows[i]) begin
      issue(rows[i][41:28], rows[i][27:20]);
      chk({file_we_o, file_wdata_o, w_o, carry_o, nibble_overflow_bit_o, zero_o, program_counter_o},
        {rows[i][19:0], 15'(i + 1)});
      chk(file_raddr_o, rows[i][34:28]);
      if (rows[i][19])
        chk(file_waddr_o, rows[i][34:28]);
    end
    $display("table done");
    flow(14'h1980, 8'hF7, 1'b1, 15'h0002);
    flow(14'h1980, 8'h08, 1'b0, 15'h0001);
    flow(14'h1F80, 8'h80, 1'b1, 15'h0002);
    flow(14'h1F80, 8'h7F, 1'b0, 15'h0001);
    flow(14'h3300, 8'h00, 1'b1, 15'h7F01);
    flow(14'h32FF, 8'h00, 1'b1, 15'h0100);
    issue(14'h3300, 8'h00);
    resetn_i = 0;
    #1 chk({program_counter_o, w_o, carry_o, nibble_overflow_bit_o, zero_o, no_op_cycle_o, file_we_o}, 0);
    @(posedge core_clk_i);
    #1 resetn_i = 1;
    issue(14'h1001, 8'hFF);
    chk({program_counter_o, file_we_o, file_wdata_o, file_waddr_o, no_op_cycle_o, instr_done_o},
      {15'h0001, 1'b1, 8'hFE, 7'h01, 2'b01});
    $display("reset done");
    give_verdict;
  end
endmodule
`default_nettype wire
